/* File: logic/spacing_pkg.sv */
/*
  Constants and carrier types for the threshold adjustment spacing register.
  Assumes a byte-wide internal register port fed by the serial management engine.
*/
package spacing_pkg;
  localparam logic [7:0] SPACING_ADDR = 8'h37;
  localparam logic [7:0] SPACING_RESET = 8'h00;
  localparam int REMOTE_A_LSB = 0;
  localparam int LOCAL_LSB = 3;
  localparam int REMOTE_B_LSB = 6;
  localparam int CODE_W = 3;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] DEC_BASE_CYCLES = 11'h004;
  localparam logic [CNT_W-1:0] INC_BASE_CYCLES = 11'h008;
  localparam logic [CNT_W-1:0] CNT_MAX = 11'h7ff;
  localparam int NUM_CH = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

/* File: logic/threshold_spacing.sv */
/*
  Threshold adjustment spacing register and per-channel spacing counters.
  Assumes the register request, lock, companion bit, cycle tick and
  adjustment pulses all come from logic on clk.
*/
// What this block does
// - Writes to the spacing register are ignored once the lock is set.
// - Reset loads the spacing register with zero, shortest spacing.
// - Bits 2:0 give the first remote channel spacing code.
// - Decrease spacing is 4 cycles at code 0, doubling to 512.
// - Increase spacing is 8 cycles at code 0, doubling to 1024.
// - Bits 5:3 give the local channel code, same encoding.
// - Bits 7:6 hold the two low bits of the second remote code.
// - Second remote channel spaced by the combined three-bit code.
// - Second remote code MSB comes from companion register bit 0.
`timescale 1ns/1ps
module threshold_spacing
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire spacing_pkg::reg_req_s req,
  output logic [7:0] rd_data_reg,
  // Control inputs
  input wire logic config_lock,
  input wire logic remote_b_code_msb,
  input wire logic monitor_cycle_done,
  input wire logic [spacing_pkg::NUM_CH-1:0] adjust_done,
  // Per-channel permission to adjust (0 remote a, 1 local, 2 remote b)
  output logic [spacing_pkg::NUM_CH-1:0] dec_ready_reg,
  output logic [spacing_pkg::NUM_CH-1:0] inc_ready_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Spacing decode

  function automatic logic [spacing_pkg::CNT_W-1:0] spacing_cycles(
    input logic [spacing_pkg::CNT_W-1:0] base,
    input logic [spacing_pkg::CODE_W-1:0] code);
    spacing_cycles = base << code;
  endfunction

  logic [7:0] spacing_reg;
  logic [7:0] spacing_next;
  logic [7:0] rd_data_next;
  logic [spacing_pkg::CODE_W-1:0] code [spacing_pkg::NUM_CH];
  logic [spacing_pkg::CNT_W-1:0] cnt_reg [spacing_pkg::NUM_CH];
  logic [spacing_pkg::CNT_W-1:0] cnt_next [spacing_pkg::NUM_CH];
  logic [spacing_pkg::NUM_CH-1:0] dec_ready_next;
  logic [spacing_pkg::NUM_CH-1:0] inc_ready_next;
  logic wr_hit;

  always_comb
  begin
    code[0] = spacing_reg[spacing_pkg::REMOTE_A_LSB +: spacing_pkg::CODE_W];
    code[1] = spacing_reg[spacing_pkg::LOCAL_LSB +: spacing_pkg::CODE_W];
    code[2] = {remote_b_code_msb, spacing_reg[spacing_pkg::REMOTE_B_LSB +: 2]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register

  assign wr_hit = req.wr && (req.addr == spacing_pkg::SPACING_ADDR);

  always_comb
  begin
    spacing_next = spacing_reg;
    // Lock only blocks writes; reads keep returning the held value
    if (wr_hit && !config_lock)
    begin
      spacing_next = req.wdata;
    end
    rd_data_next = (req.addr == spacing_pkg::SPACING_ADDR) ? spacing_reg : 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      spacing_reg <= spacing_pkg::SPACING_RESET;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      spacing_reg <= spacing_next;
      rd_data_reg <= rd_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spacing counters

  always_comb
  begin
    for (int i = 0; i < spacing_pkg::NUM_CH; i++)
    begin
      cnt_next[i] = cnt_reg[i];
      // An adjustment restarts the interval even if a tick lands with it
      if (adjust_done[i])
      begin
        cnt_next[i] = '0;
      end
      else if (monitor_cycle_done && cnt_reg[i] != spacing_pkg::CNT_MAX)
      begin
        cnt_next[i] = cnt_reg[i] + 11'h001;
      end
      dec_ready_next[i] = cnt_reg[i] >= spacing_cycles(spacing_pkg::DEC_BASE_CYCLES, code[i]);
      inc_ready_next[i] = cnt_reg[i] >= spacing_cycles(spacing_pkg::INC_BASE_CYCLES, code[i]);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < spacing_pkg::NUM_CH; i++)
      begin
        cnt_reg[i] <= '0;
      end
      dec_ready_reg <= '0;
      inc_ready_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < spacing_pkg::NUM_CH; i++)
      begin
        cnt_reg[i] <= cnt_next[i];
      end
      dec_ready_reg <= dec_ready_next;
      inc_ready_reg <= inc_ready_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_lock_blocks;
    @(posedge clk) disable iff (rst)
    config_lock && wr_hit |=> spacing_reg == $past(spacing_reg);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked write changed register");

  property p_reset_value;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> spacing_reg == 8'h00 && dec_ready_reg == 3'h0;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("register not zero after reset");

  property p_write_read;
    @(posedge clk) disable iff (rst)
    !config_lock && wr_hit ##1 (req.addr == 8'h37 && !req.wr) |=> rd_data_reg == $past(req.wdata, 2);
  endproperty
  a_write_read: assert property (p_write_read) else $error("write not read back");

  property p_remote_a_dec;
    @(posedge clk) disable iff (rst)
    !adjust_done[0] && cnt_reg[0] == (11'h004 << spacing_reg[2:0]) |=> dec_ready_reg[0];
  endproperty
  a_remote_a_dec: assert property (p_remote_a_dec) else $error("remote a decrease late");

  property p_remote_a_dec_early;
    @(posedge clk) disable iff (rst)
    cnt_reg[0] < (11'h004 << spacing_reg[2:0]) |=> !dec_ready_reg[0];
  endproperty
  a_remote_a_dec_early: assert property (p_remote_a_dec_early) else $error("decrease early");

  property p_remote_a_inc_early;
    @(posedge clk) disable iff (rst)
    cnt_reg[0] < (11'h008 << spacing_reg[2:0]) |=> !inc_ready_reg[0];
  endproperty
  a_remote_a_inc_early: assert property (p_remote_a_inc_early) else $error("increase early");

  property p_local_dec;
    @(posedge clk) disable iff (rst)
    cnt_reg[1] >= (11'h004 << spacing_reg[5:3]) |=> dec_ready_reg[1];
  endproperty
  a_local_dec: assert property (p_local_dec) else $error("local decrease wrong");

  property p_remote_b_inc;
    @(posedge clk) disable iff (rst)
    cnt_reg[2] >= (11'h008 << {remote_b_code_msb, spacing_reg[7:6]}) |=> inc_ready_reg[2];
  endproperty
  a_remote_b_inc: assert property (p_remote_b_inc) else $error("remote b increase wrong");

  property p_remote_b_msb;
    @(posedge clk) disable iff (rst)
    remote_b_code_msb && cnt_reg[2] < 11'h010 |=> !dec_ready_reg[2];
  endproperty
  a_remote_b_msb: assert property (p_remote_b_msb) else $error("msb ignored");

  property p_count_step;
    @(posedge clk) disable iff (rst)
    monitor_cycle_done && !adjust_done[1] && cnt_reg[1] < 11'h7ff
      |=> cnt_reg[1] == $past(cnt_reg[1]) + 11'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_adjust_clears;
    @(posedge clk) disable iff (rst)
    adjust_done[2] |=> cnt_reg[2] == 11'h000;
  endproperty
  a_adjust_clears: assert property (p_adjust_clears) else $error("restart missed");

  property p_local_inc_early;
    @(posedge clk) disable iff (rst)
    cnt_reg[1] < (11'h008 << spacing_reg[5:3]) |=> !inc_ready_reg[1];
  endproperty
  a_local_inc_early: assert property (p_local_inc_early) else $error("local inc early");

  property p_remote_b_dec;
    @(posedge clk) disable iff (rst)
    cnt_reg[2] >= (11'h004 << {remote_b_code_msb, spacing_reg[7:6]}) |=> dec_ready_reg[2];
  endproperty
  a_remote_b_dec: assert property (p_remote_b_dec) else $error("remote b dec wrong");

  c_locked_write: cover property (@(posedge clk) disable iff (rst) config_lock && wr_hit);
  c_slow_inc: cover property (@(posedge clk) disable iff (rst)
    code[0] == 3'h7 && $rose(inc_ready_reg[0]));
  c_remote_b_high: cover property (@(posedge clk) disable iff (rst)
    remote_b_code_msb && $rose(dec_ready_reg[2]));
  c_restart: cover property (@(posedge clk) disable iff (rst) adjust_done[1] && dec_ready_reg[1]);

endmodule // threshold_spacing

/* File: verif/threshold_spacing_tb.sv */
/*
  Self-checking bench for the threshold adjustment spacing register and counters.
  Assumes the design carries its own assertions and clk runs at 10 MHz.
*/
`timescale 1ns/1ps
module threshold_spacing_tb;
  logic clk;
  logic rst;
  spacing_pkg::reg_req_s req;
  logic [7:0] rd_data_reg;
  logic config_lock;
  logic remote_b_code_msb;
  logic monitor_cycle_done;
  logic [2:0] adjust_done;
  logic [2:0] dec_ready_reg;
  logic [2:0] inc_ready_reg;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  threshold_spacing u_dut (.clk(clk), .rst(rst), .req(req), .rd_data_reg(rd_data_reg),
    .config_lock(config_lock), .remote_b_code_msb(remote_b_code_msb),
    .monitor_cycle_done(monitor_cycle_done), .adjust_done(adjust_done),
    .dec_ready_reg(dec_ready_reg), .inc_ready_reg(inc_ready_reg));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    num_checks++;
    if (seen !== expected)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  // Extra edge before sampling so the registered read data has settled
  task automatic read_reg(input logic [7:0] a, input logic [7:0] expected);
    @(posedge clk) req.addr <= a;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk) check(rd_data_reg, expected);
  endtask
  function automatic logic [2:0] due(int n, int base, logic [7:0] r, logic msb);
    due = {n >= (base << {msb, r[7:6]}), n >= (base << r[5:3]), n >= (base << r[2:0])};
  endfunction
  // Clears all counts first, so a stale ready from the last run cannot show up as a mismatch
  task automatic run(input logic [7:0] r, input logic msb, input int ticks);
    write_reg(spacing_pkg::SPACING_ADDR, r);
    remote_b_code_msb <= msb;
    adjust_done <= 3'h7;
    @(posedge clk) adjust_done <= 3'h0;
    for (int n = 1; n <= ticks; n++)
    begin
      @(posedge clk) monitor_cycle_done <= 1'b1;
      @(posedge clk) monitor_cycle_done <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check({5'h00, dec_ready_reg}, {5'h00, due(n, 4, r, msb)});
      check({5'h00, inc_ready_reg}, {5'h00, due(n, 8, r, msb)});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    config_lock = 1'b0;
    remote_b_code_msb = 1'b0;
    monitor_cycle_done = 1'b0;
    adjust_done = 3'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    read_reg(spacing_pkg::SPACING_ADDR, 8'h00);
    write_reg(spacing_pkg::SPACING_ADDR, 8'ha5);
    read_reg(spacing_pkg::SPACING_ADDR, 8'ha5);
    write_reg(8'h38, 8'h3c);
    read_reg(8'h38, 8'h00);
    read_reg(spacing_pkg::SPACING_ADDR, 8'ha5);
    // Codes 0 to 7 all appear across the three runs
    run(8'h50, 1'b1, 260);
    run(8'hff, 1'b0, 1030);
    run(8'h31, 1'b1, 520);
    @(posedge clk) config_lock <= 1'b1;
    write_reg(spacing_pkg::SPACING_ADDR, 8'h00);
    read_reg(spacing_pkg::SPACING_ADDR, 8'h31);
    end_of_test();
  end
endmodule // threshold_spacing_tb
